// *** logic/pwa_params.svh ***
// constants of the wake event aggregator: register indices, field positions, resets
// assumes a bus whose byte address is four times the register index
`ifndef PWA_PARAMS_SVH
`define PWA_PARAMS_SVH

// register indices (byte address = index * 4)
`define PWA_IDX_SEL      10'h007
`define PWA_IDX_ACT      10'h030
`define PWA_IDX_ALLOW    10'h0f0
`define PWA_IDX_PEND     10'h0f1
`define PWA_IDX_IRQ_STAT 10'h040
`define PWA_IDX_IRQ_MASK 10'h041

// logical function codes
`define PWA_FN_FLOPPY  8'h00
`define PWA_FN_SER1    8'h01
`define PWA_FN_SER2    8'h02
`define PWA_FN_PRINTER 8'h03
`define PWA_FN_HWMON   8'h04
`define PWA_FN_GPIO    8'h06
`define PWA_FN_WAKE    8'h0a

// field positions in allow, pending and activation registers
`define PWA_BIT_FLOPPY  0
`define PWA_BIT_SER1    1
`define PWA_BIT_SER2    2
`define PWA_BIT_PRINTER 3
`define PWA_BIT_HWMON   4
`define PWA_BIT_ON      0

// interrupt status fields
`define PWA_IRQ_WAKE_ROSE 0
`define PWA_IRQ_REFUSED   1

// reset values
`define PWA_RST_SEL  8'h00
`define PWA_RST_ON   1'b0
`define PWA_RST_SRC  5'h00
`define PWA_RST_IRQ  2'h0

`endif

// *** logic/pwa_pkg.sv ***
// types of the wake event aggregator
// assumes a 32-bit classic bus with a 12-bit byte address
package pwa_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pwa_wb_req_t;

  typedef struct packed {
    logic [7:0]  sel_fn;
    logic        wake_on;
    logic [4:0]  allow;
    logic [4:0]  pending;
    logic [4:0]  src_meta;
    logic [4:0]  src_sync;
    logic [4:0]  src_prev;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        ack;
    logic [31:0] dat;
    logic        wake;
    logic        irq;
  } pwa_state_t;

endpackage : pwa_pkg

// *** logic/pwa_top.sv ***
// wake event aggregator: function selector, wake enable, per-source allow and pending flags
// assumes a classic wishbone master on clk_i and asynchronous source event levels
//
// Functional notes
// - 8-bit selector picks function 00,01,02,03,04,06,0a; others reserved.
// - activation bit 0 turns the wake output off or on; pending flags still capture events.
// - allow bit 4 passes hardware monitor wake events; resets to zero.
// - allow bit 3 passes printer port wake events.
// - allow bit 2 passes second serial port wake events; resets to zero.
// - allow bit 1 passes first serial port wake events; resets to zero.
// - allow bit 0 passes floppy controller wake events; resets to zero.
// - pending register holds one flag per source at bits 4 to 0.
// - writing one clears a pending flag; flags written zero stay.
// - bits 7 to 5 of allow and pending registers are reserved.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ns
`include "pwa_params.svh"

module pwa_top #(
  parameter int NSRC = 5
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // register bus
  input  wire pwa_pkg::pwa_wb_req_t wb_req_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // wake sources, asynchronous levels
  input  wire logic [NSRC-1:0]      src_event_i,
  // outputs
  output logic                      wake_o,
  output logic                      irq_o
);
  import pwa_pkg::*;

  // ****************************************
  // decode helper
  // ****************************************
  function automatic logic hit(input logic [11:0] adr, input logic [9:0] idx);
    hit = (adr[11:2] == idx);
  endfunction : hit

  // the three registers that belong to the wake function
  function automatic logic fn_reg(input logic [11:0] adr);
    fn_reg = hit(adr, `PWA_IDX_ACT) | hit(adr, `PWA_IDX_ALLOW) | hit(adr, `PWA_IDX_PEND);
  endfunction : fn_reg

  pwa_state_t q;
  pwa_state_t d;

  logic       req;
  logic       wr;
  logic       rd;
  logic       wake_sel;
  logic [4:0] rise;
  logic       resv_fn;

  assign req      = wb_req_i.cyc & wb_req_i.stb & ~q.ack;
  assign wr       = req & wb_req_i.we & wb_req_i.sel[0];
  assign rd       = req & ~wb_req_i.we;
  assign wake_sel = (q.sel_fn == `PWA_FN_WAKE);
  assign rise     = q.src_sync & ~q.src_prev;

  // reserved codes: anything outside the listed functions
  always_comb begin
    unique case (q.sel_fn)
      `PWA_FN_FLOPPY, `PWA_FN_SER1, `PWA_FN_SER2, `PWA_FN_PRINTER,
      `PWA_FN_HWMON, `PWA_FN_GPIO, `PWA_FN_WAKE: resv_fn = 1'b0;
      default:                                    resv_fn = 1'b1;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic       fn_hit;
    logic [1:0] irq_ev;
    fn_hit = 1'b0;
    irq_ev = 2'b00;
    d = q;

    // two-stage synchroniser, then rising edge detect
    d.src_meta = src_event_i;
    d.src_sync = q.src_meta;
    d.src_prev = q.src_sync;

    d.ack = req;
    d.dat = 32'h0;

    fn_hit = fn_reg(wb_req_i.adr);
    // function registers reached while another function is selected
    if (req && fn_hit && !wake_sel) begin
      irq_ev[`PWA_IRQ_REFUSED] = 1'b1;
    end

    if (wr) begin
      if (hit(wb_req_i.adr, `PWA_IDX_SEL)) begin
        d.sel_fn = wb_req_i.dat[7:0];
      end
      if (wake_sel && hit(wb_req_i.adr, `PWA_IDX_ACT)) begin
        d.wake_on = wb_req_i.dat[`PWA_BIT_ON];
      end
      if (wake_sel && hit(wb_req_i.adr, `PWA_IDX_ALLOW)) begin
        d.allow = wb_req_i.dat[4:0];
      end
      if (wake_sel && hit(wb_req_i.adr, `PWA_IDX_PEND)) begin
        d.pending = q.pending & ~wb_req_i.dat[4:0];
      end
      if (hit(wb_req_i.adr, `PWA_IDX_IRQ_MASK)) begin
        d.irq_mask = wb_req_i.dat[1:0];
      end
    end

    // a new event wins over a clear in the same cycle
    d.pending = d.pending | rise;

    if (rd) begin
      if (hit(wb_req_i.adr, `PWA_IDX_SEL)) begin
        d.dat = {24'h0, q.sel_fn};
      end else if (wake_sel && hit(wb_req_i.adr, `PWA_IDX_ACT)) begin
        d.dat = {31'h0, q.wake_on};
      end else if (wake_sel && hit(wb_req_i.adr, `PWA_IDX_ALLOW)) begin
        d.dat = {27'h0, q.allow};
      end else if (wake_sel && hit(wb_req_i.adr, `PWA_IDX_PEND)) begin
        d.dat = {27'h0, q.pending};
      end else if (hit(wb_req_i.adr, `PWA_IDX_IRQ_STAT)) begin
        d.dat = {30'h0, q.irq_stat};
      end else if (hit(wb_req_i.adr, `PWA_IDX_IRQ_MASK)) begin
        d.dat = {30'h0, q.irq_mask};
      end
    end

    d.wake = d.wake_on & (|(d.pending & d.allow));
    irq_ev[`PWA_IRQ_WAKE_ROSE] = d.wake & ~q.wake;

    // read clears status; events arriving now survive the clear
    if (rd && hit(wb_req_i.adr, `PWA_IDX_IRQ_STAT)) begin
      d.irq_stat = 2'b00;
    end
    d.irq_stat = d.irq_stat | irq_ev;
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.sel_fn   <= `PWA_RST_SEL;
      q.wake_on  <= `PWA_RST_ON;
      q.allow    <= `PWA_RST_SRC;
      q.pending  <= `PWA_RST_SRC;
      q.src_meta <= `PWA_RST_SRC;
      q.src_sync <= `PWA_RST_SRC;
      q.src_prev <= `PWA_RST_SRC;
      q.irq_stat <= `PWA_RST_IRQ;
      q.irq_mask <= `PWA_RST_IRQ;
      q.ack      <= 1'b0;
      q.dat      <= 32'h0;
      q.wake     <= 1'b0;
      q.irq      <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign wake_o   = q.wake;
  assign irq_o    = q.irq;

  // ****************************************
  // checks
  // ****************************************
  chk_sel_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(wb_req_i.adr, `PWA_IDX_SEL)) |=> (q.sel_fn == $past(wb_req_i.dat[7:0])))
    else $error("selector not loaded by write");

  chk_gate_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.wake_on |-> !wake_o)
    else $error("wake output high while function disabled");

  chk_allow_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (q.allow == 5'h00) && (q.pending == 5'h00))
    else $error("allow or pending not zero after reset");

  chk_allow_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_o |-> |(q.pending & q.allow))
    else $error("wake output without an allowed pending source");

  chk_pend_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    (rise != 5'h00) |=> ((q.pending & $past(rise)) == $past(rise)))
    else $error("source edge not captured in pending");

  chk_w1c_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wake_sel && hit(wb_req_i.adr, `PWA_IDX_PEND) && rise == 5'h00)
    |=> (q.pending == ($past(q.pending) & ~$past(wb_req_i.dat[4:0]))))
    else $error("write one to clear misbehaved");

  chk_resv_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wake_sel && (hit(wb_req_i.adr, `PWA_IDX_ALLOW) || hit(wb_req_i.adr, `PWA_IDX_PEND)))
    |=> wb_ack_o && (wb_dat_o[31:5] == 27'h0))
    else $error("reserved bits read nonzero");

  chk_wake_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.wake_on && |(q.pending & q.allow)) |-> wake_o)
    else $error("wake output low while an allowed source pends");

  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");

  chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> |(q.irq_stat & q.irq_mask))
    else $error("interrupt without unmasked status");

  // ****************************************
  // selector checks
  // ****************************************
  chk_sel_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit(wb_req_i.adr, `PWA_IDX_SEL)) |=> (q.sel_fn == $past(q.sel_fn)))
    else $error("selector changed without a write");

  chk_sel_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && hit(wb_req_i.adr, `PWA_IDX_SEL)) |=> (wb_dat_o == {24'h0, $past(q.sel_fn)}))
    else $error("selector read back wrong");

  chk_refuse_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wake_sel && fn_reg(wb_req_i.adr)) |=> q.irq_stat[`PWA_IRQ_REFUSED])
    else $error("refused function access not flagged");

  chk_resv_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && resv_fn && fn_reg(wb_req_i.adr)) |=> (wb_dat_o == 32'h0))
    else $error("function register visible under a reserved code");

  chk_sel_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && !wake_sel && fn_reg(wb_req_i.adr))
    |=> (q.allow == $past(q.allow)) && (q.wake_on == $past(q.wake_on)))
    else $error("function register written while not selected");

  // ****************************************
  // enable checks
  // ****************************************
  chk_act_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wake_sel && hit(wb_req_i.adr, `PWA_IDX_ACT)) |=> (q.wake_on == $past(wb_req_i.dat[`PWA_BIT_ON])))
    else $error("activation bit not loaded by write");

  chk_act_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && wake_sel && hit(wb_req_i.adr, `PWA_IDX_ACT)) |=> (q.wake_on == $past(q.wake_on)))
    else $error("activation bit changed without a write");

  chk_act_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wake_sel && hit(wb_req_i.adr, `PWA_IDX_ACT)) |=> (wb_dat_o[31:1] == 31'h0))
    else $error("reserved activation bits read nonzero");

  chk_allow_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wake_sel && hit(wb_req_i.adr, `PWA_IDX_ALLOW)) |=> (q.allow == $past(wb_req_i.dat[4:0])))
    else $error("allow bits not loaded by write");

  chk_allow_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && wake_sel && hit(wb_req_i.adr, `PWA_IDX_ALLOW)) |=> (q.allow == $past(q.allow)))
    else $error("allow bits changed without a write");

  chk_allow_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wake_sel && hit(wb_req_i.adr, `PWA_IDX_ALLOW)) |=> (wb_dat_o[4:0] == $past(q.allow)))
    else $error("allow bits read back wrong");

  // ****************************************
  // pending and synchroniser checks
  // ****************************************
  chk_pend_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wake_sel && hit(wb_req_i.adr, `PWA_IDX_PEND)) |=> (wb_dat_o[4:0] == $past(q.pending)))
    else $error("pending flags read back wrong");

  chk_pend_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && wake_sel && hit(wb_req_i.adr, `PWA_IDX_PEND))
    |=> ((q.pending & $past(q.pending)) == $past(q.pending)))
    else $error("pending flag lost without a clear");

  chk_w1c_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wake_sel && hit(wb_req_i.adr, `PWA_IDX_PEND))
    |=> ((q.pending & $past(q.pending & ~wb_req_i.dat[4:0])) == $past(q.pending & ~wb_req_i.dat[4:0])))
    else $error("flag written with zero was cleared");

  chk_sync_path: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (q.src_sync == $past(q.src_meta)))
    else $error("synchroniser stage skipped");

  // ****************************************
  // bus checks
  // ****************************************
  chk_idle_data: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h0))
    else $error("read data driven outside an answer");

  chk_ack_only_req: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !wb_ack_o)
    else $error("bus answer without a request");

  chk_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && !fn_reg(wb_req_i.adr) && !hit(wb_req_i.adr, `PWA_IDX_SEL) && !hit(wb_req_i.adr, `PWA_IDX_IRQ_STAT)
     && !hit(wb_req_i.adr, `PWA_IDX_IRQ_MASK)) |=> (wb_dat_o == 32'h0))
    else $error("unmapped read returned data");

  // ****************************************
  // interrupt checks
  // ****************************************
  chk_stat_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && hit(wb_req_i.adr, `PWA_IDX_IRQ_STAT)) |=> (wb_dat_o[1:0] == $past(q.irq_stat)))
    else $error("interrupt status read back wrong");

  chk_stat_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    !(rd && hit(wb_req_i.adr, `PWA_IDX_IRQ_STAT)) |=> ((q.irq_stat & $past(q.irq_stat)) == $past(q.irq_stat)))
    else $error("interrupt status lost without a read");

  chk_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(wb_req_i.adr, `PWA_IDX_IRQ_MASK)) |=> (q.irq_mask == $past(wb_req_i.dat[1:0])))
    else $error("interrupt mask not loaded by write");

  chk_wake_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wake_o) |-> q.irq_stat[`PWA_IRQ_WAKE_ROSE])
    else $error("wake rise not recorded");

  chk_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(q.irq_stat & q.irq_mask)) |-> irq_o)
    else $error("unmasked status without interrupt");

  // ****************************************
  // per source checks
  // ****************************************
  for (genvar s = 0; s < NSRC; s++) begin : g_src
    chk_src_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      rise[s] |=> q.pending[s])
      else $error("source edge not held in its flag");

    chk_src_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.wake_on && q.allow[s] && q.pending[s]) |-> wake_o)
      else $error("allowed source did not raise wake output");

    chk_src_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && wake_sel && hit(wb_req_i.adr, `PWA_IDX_PEND) && wb_req_i.dat[s] && !rise[s])
      |=> !q.pending[s])
      else $error("flag not cleared by writing one");

    chk_src_keep: assert property (@(posedge clk_i) disable iff (rst_i)
      (q.pending[s] && !(wr && wake_sel && hit(wb_req_i.adr, `PWA_IDX_PEND) && wb_req_i.dat[s]))
      |=> q.pending[s])
      else $error("flag cleared without writing one");
  end

endmodule : pwa_top

// *** dv/pwa_top_tb_top.sv ***
// testbench of the wake event aggregator: register bus tasks and directed scenarios
// assumes pwa_pkg and pwa_params.svh on the search path, 20 MHz clock
`timescale 1ns/1ns
`include "pwa_params.svh"

module pwa_top_tb_top;
  import pwa_pkg::*;

  localparam logic [11:0] A_SEL   = {`PWA_IDX_SEL, 2'b00};
  localparam logic [11:0] A_ACT   = {`PWA_IDX_ACT, 2'b00};
  localparam logic [11:0] A_ALLOW = {`PWA_IDX_ALLOW, 2'b00};
  localparam logic [11:0] A_PEND  = {`PWA_IDX_PEND, 2'b00};
  localparam logic [11:0] A_STAT  = {`PWA_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK  = {`PWA_IDX_IRQ_MASK, 2'b00};

  logic        clk_i;
  logic        rst_i;
  pwa_wb_req_t req;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [4:0]  src_event_i;
  logic        wake_o;
  logic        irq_o;
  int          num_errors;
  int          cmp_count;
  logic [31:0] rd;
  logic [7:0]  fn_codes [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h0a};

  pwa_top u_pwa_top (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wb_req_i    (req),
    .wb_dat_o    (wb_dat_o),
    .wb_ack_o    (wb_ack_o),
    .src_event_i (src_event_i),
    .wake_o      (wake_o),
    .irq_o       (irq_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic test_done;
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] wd, output logic [31:0] q);
    int n;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) begin
        num_errors++;
        $display("mismatch at %0t: bus answer timed out", $time);
        test_done();
      end
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [11:0] adr, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, adr, {24'h0, d}, q);
  endtask : wr

  task automatic rdchk(input logic [11:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 32'h0, rd);
    chk(rd, {24'h0, exp});
  endtask : rdchk

  task automatic wake_chk(input logic exp);
    repeat (4) @(posedge clk_i);
    chk({31'h0, wake_o}, {31'h0, exp});
  endtask : wake_chk

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    num_errors = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    req = '0;
    src_event_i = 5'h00;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(A_SEL, 8'h00);
    foreach (fn_codes[i]) begin
      wr(A_SEL, fn_codes[i]);
      rdchk(A_SEL, fn_codes[i]);
    end
    rdchk(A_ALLOW, 8'h00);
    rdchk(A_PEND, 8'h00);
    wr(A_ALLOW, 8'hff);
    rdchk(A_ALLOW, 8'h1f);
    wr(A_ACT, 8'hff);
    rdchk(A_ACT, 8'h01);
    src_event_i <= 5'h1f;
    wake_chk(1'b1);
    rdchk(A_PEND, 8'h1f);
    wr(A_PEND, 8'h02);
    rdchk(A_PEND, 8'h1d);
    for (int i = 0; i < 5; i++) begin
      wr(A_ALLOW, 8'(1 << i));
      wake_chk(i != 1);
    end
    wr(A_ALLOW, 8'h1f);
    wr(A_ACT, 8'h00);
    wake_chk(1'b0);
    rdchk(A_STAT, 8'h01);
    wr(A_MASK, 8'h02);
    wr(A_SEL, `PWA_FN_SER1);
    wr(A_ALLOW, 8'h00);
    rdchk(A_ALLOW, 8'h00);
    chk({31'h0, irq_o}, 32'h1);
    rdchk(A_STAT, 8'h02);
    chk({31'h0, irq_o}, 32'h0);
    wr(A_SEL, 8'h05);
    rdchk(A_SEL, 8'h05);
    rdchk(A_ACT, 8'h00);
    chk({31'h0, irq_o}, 32'h1);
    rdchk(12'h200, 8'h00);
    wr(A_SEL, `PWA_FN_WAKE);
    rdchk(A_ALLOW, 8'h1f);
    wr(A_PEND, 8'h1f);
    rdchk(A_PEND, 8'h00);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(A_SEL, 8'h00);
    wr(A_SEL, `PWA_FN_WAKE);
    rdchk(A_ACT, 8'h00);
    rdchk(A_ALLOW, 8'h00);
    test_done();
  end
endmodule : pwa_top_tb_top
